/* File: verilog/aux_hub_master.sv */
/*
  auxiliary i2c master of the sensor hub with its banked register file.
  assumes an avalon-mm master with word addresses and one-cycle accel ready pulses.
*/
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - target address bit 0 selects read (1) or write (0).
// - sub-address is the external register read or written.
// - slot settings give the read count, zero to six bytes.
// - master config 4Ch enables slot 0, write-once, pull-ups.
// - pull-up enables follow the master config bit.
// - one-shot read ends with the end-of-operation flag set.
// - first byte read lands in the first hub output register.
// - continuous reads refresh outputs on every trigger.
// - one-shot write sends the slot 0 write value.
// - write-done flag set when a one-shot write completes.
// - pass-through ties the primary lines to the aux lines.
// - six-byte read fills the first six outputs in order.
// - eighteen hub output registers; reads fill only the first six, in read order.
module aux_hub_master
  import aux_hub_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic accel_sample_ready,
  input wire logic aux_data_line_in,
  output logic aux_data_line_out,
  output logic aux_data_line_oe,
  output logic aux_clock_line_out,
  output logic aux_clock_line_oe,
  output logic aux_pullup_en,
  input wire logic pri_clock_in,
  input wire logic pri_data_in,
  output logic pri_data_out,
  output logic pri_data_oe
);
  // ==========================================================
  // state
  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic [7:0] bank;
    logic [7:0] tgt;
    logic [7:0] sub;
    logic [7:0] cfg;
    logic [7:0] wval;
    logic [7:0] mcfg;
    logic [HUB_REGS-1:0][7:0] hub;
    logic endop;
    logic wdone;
    logic [1:0] irq_st;
    logic [1:0] irq_en;
    logic irq;
    fsm_t fsm;
    logic [1:0] phase;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [2:0] step;
    logic [2:0] left;
    logic [4:0] ptr;
    logic nack;
    logic once;
    logic scl_lo;
    logic sda_lo;
    logic [2:0] drv_hist;
    logic pri_lo;
    logic trig_d;
  } hub_t;
  hub_t st_ff;
  hub_t nxt_st;
  logic [2:0] sync_q;
  logic sda_s;
  logic pscl_s;
  logic psda_s;
  logic take;
  logic wr;
  logic [7:0] wd;
  logic in_hub;
  logic [7:0] hoff;
  logic [7:0] rd_val;
  logic rd_flags;
  logic trig;
  logic ev_end;
  logic ev_wd;
  logic [2:0] numop;
  tick_if tk ();
  // ==========================================================
  // input synchronisers and bit timer
  sync_2ff #(.W(3)) u_sync (
    .clk(clk),
    .reset(reset),
    .d({aux_data_line_in, pri_clock_in, pri_data_in}),
    .q(sync_q)
  );
  assign sda_s = sync_q[2];
  assign pscl_s = sync_q[1];
  assign psda_s = sync_q[0];
  bit_timer #(.DIV(QUARTER)) u_timer (
    .clk(clk),
    .reset(reset),
    .tk(tk)
  );
  assign tk.run = (st_ff.fsm != S_IDLE);
  // ==========================================================
  // register read mux
  assign take = (avs_read | avs_write) & st_ff.waitreq;
  assign wr = avs_write & st_ff.waitreq;
  assign wd = avs_writedata[7:0];
  assign in_hub = (st_ff.bank == BANK_HUB);
  assign hoff = avs_address - IDX_HUB1;
  assign numop = (st_ff.cfg[2:0] > MAX_READ) ? MAX_READ : st_ff.cfg[2:0];
  always_comb begin
    rd_val = 8'h00;
    if (avs_address == IDX_BANK) begin
      rd_val = st_ff.bank;
    end else if (avs_address == IDX_FLAGS) begin
      rd_val = {st_ff.wdone, 6'h00, st_ff.endop};
    end else if (in_hub) begin
      if (avs_address == IDX_TGT) rd_val = st_ff.tgt;
      if (avs_address == IDX_SUB) rd_val = st_ff.sub;
      if (avs_address == IDX_CFG) rd_val = st_ff.cfg;
      if (avs_address == IDX_WVAL) rd_val = st_ff.wval;
      if (avs_address == IDX_MCFG) rd_val = st_ff.mcfg;
      if (hoff < 8'(HUB_REGS)) rd_val = st_ff.hub[hoff[4:0]];
    end else begin
      if (avs_address == IDX_IRQ_ST) rd_val = {6'h00, st_ff.irq_st};
      if (avs_address == IDX_IRQ_EN) rd_val = {6'h00, st_ff.irq_en};
    end
  end
  assign rd_flags = avs_read & st_ff.waitreq & (avs_address == IDX_FLAGS);
  // ==========================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    ev_end = 1'b0;
    ev_wd = 1'b0;
    trig = accel_sample_ready & ~st_ff.trig_d;
    nxt_st.trig_d = accel_sample_ready;
    // one wait state, then the answer; unmapped reads give zero
    nxt_st.waitreq = ~take;
    if (take) begin
      nxt_st.rdata = {24'h0, rd_val};
    end
    if (wr) begin
      if (avs_address == IDX_BANK) nxt_st.bank = wd;
      if (in_hub && avs_address == IDX_TGT) nxt_st.tgt = wd;
      if (in_hub && avs_address == IDX_SUB) nxt_st.sub = wd;
      if (in_hub && avs_address == IDX_CFG) nxt_st.cfg = wd;
      if (in_hub && avs_address == IDX_WVAL) nxt_st.wval = wd;
      if (in_hub && avs_address == IDX_MCFG) begin
        nxt_st.mcfg = wd;
        nxt_st.once = 1'b0;
      end
      if (!in_hub && avs_address == IDX_IRQ_EN) nxt_st.irq_en = wd[1:0];
      if (!in_hub && avs_address == IDX_IRQ_CLR) nxt_st.irq_st = st_ff.irq_st & ~wd[1:0];
    end
    // ---- aux engine; a disabled master still finishes its transfer
    unique case (st_ff.fsm)
      S_IDLE: begin
        nxt_st.sda_lo = 1'b0;
        nxt_st.scl_lo = 1'b0;
        // writes run once under write-once; reads repeat on every trigger
        if (trig && st_ff.mcfg[MC_ON] && !st_ff.mcfg[MC_EXT] && !st_ff.mcfg[MC_PASS] &&
            !(!st_ff.tgt[0] && st_ff.mcfg[MC_ONCE] && st_ff.once)) begin
          nxt_st.fsm = S_START;
          nxt_st.phase = 2'h0;
          nxt_st.nack = 1'b0;
        end
        if (st_ff.mcfg[MC_PASS]) begin
          // primary drives aux; echo aux lows back only when not self-made
          nxt_st.scl_lo = ~pscl_s;
          nxt_st.sda_lo = ~psda_s;
        end
      end
      S_START: begin
        if (tk.tick) begin
          nxt_st.phase = st_ff.phase + 2'h1;
          if (st_ff.phase == 2'h1) nxt_st.sda_lo = 1'b1;
          if (st_ff.phase == 2'h2) nxt_st.scl_lo = 1'b1;
          if (st_ff.phase == 2'h3) begin
            nxt_st.fsm = S_BYTE;
            nxt_st.sh = {st_ff.tgt[7:1], 1'b0};
            nxt_st.bitn = 4'h0;
            nxt_st.step = 3'h0;
          end
        end
      end
      S_RESTART: begin
        if (tk.tick) begin
          nxt_st.phase = st_ff.phase + 2'h1;
          if (st_ff.phase == 2'h0) nxt_st.sda_lo = 1'b0;
          if (st_ff.phase == 2'h1) nxt_st.scl_lo = 1'b0;
          if (st_ff.phase == 2'h2) nxt_st.sda_lo = 1'b1;
          if (st_ff.phase == 2'h3) begin
            nxt_st.scl_lo = 1'b1;
            nxt_st.fsm = S_BYTE;
            nxt_st.sh = {st_ff.tgt[7:1], 1'b1};
            nxt_st.bitn = 4'h0;
            nxt_st.step = 3'h3;
          end
        end
      end
      S_BYTE: begin
        if (tk.tick) begin
          nxt_st.phase = st_ff.phase + 2'h1;
          unique case (st_ff.phase)
            2'h0: begin
              if (st_ff.step == 3'h4) begin
                // master acks every byte but the last
                nxt_st.sda_lo = (st_ff.bitn == 4'h8) && (st_ff.left != 3'h1);
              end else begin
                nxt_st.sda_lo = (st_ff.bitn != 4'h8) && !st_ff.sh[7];
              end
            end
            2'h1: nxt_st.scl_lo = 1'b0;
            2'h2: begin
              if (st_ff.bitn != 4'h8) begin
                nxt_st.sh = {st_ff.sh[6:0], sda_s};
              end else if (st_ff.step != 3'h4) begin
                nxt_st.nack = sda_s;
              end
            end
            2'h3: begin
              nxt_st.scl_lo = 1'b1;
              nxt_st.bitn = st_ff.bitn + 4'h1;
              if (st_ff.bitn == 4'h8) begin
                nxt_st.bitn = 4'h0;
                unique case (st_ff.step)
                  3'h0: begin
                    nxt_st.sh = st_ff.sub;
                    nxt_st.step = 3'h1;
                  end
                  3'h1: begin
                    if (st_ff.tgt[0]) begin
                      nxt_st.fsm = S_RESTART;
                    end else begin
                      nxt_st.sh = st_ff.wval;
                      nxt_st.step = 3'h2;
                    end
                  end
                  3'h2: nxt_st.fsm = S_STOP;
                  3'h3: begin
                    nxt_st.step = 3'h4;
                    nxt_st.left = numop;
                    nxt_st.ptr = 5'h0;
                    if (numop == 3'h0) nxt_st.fsm = S_STOP;
                  end
                  default: begin
                    nxt_st.hub[st_ff.ptr] = st_ff.sh;
                    nxt_st.ptr = st_ff.ptr + 5'h1;
                    nxt_st.left = st_ff.left - 3'h1;
                    if (st_ff.left == 3'h1) nxt_st.fsm = S_STOP;
                  end
                endcase
                if (st_ff.nack && st_ff.step != 3'h4) nxt_st.fsm = S_STOP;
              end
            end
          endcase
        end
      end
      S_STOP: begin
        if (tk.tick) begin
          nxt_st.phase = st_ff.phase + 2'h1;
          if (st_ff.phase == 2'h0) nxt_st.sda_lo = 1'b1;
          if (st_ff.phase == 2'h1) nxt_st.scl_lo = 1'b0;
          if (st_ff.phase == 2'h2) nxt_st.sda_lo = 1'b0;
          if (st_ff.phase == 2'h3) begin
            nxt_st.fsm = S_IDLE;
            ev_end = 1'b1;
            ev_wd = (st_ff.step == 3'h2);
            if (st_ff.step == 3'h2 && st_ff.mcfg[MC_ONCE]) nxt_st.once = 1'b1;
          end
        end
      end
      default: nxt_st.fsm = S_IDLE;
    endcase
    // ---- flags: set wins over the clear on read
    nxt_st.endop = (st_ff.endop & ~rd_flags) | ev_end;
    nxt_st.wdone = (st_ff.wdone & ~rd_flags) | ev_wd;
    nxt_st.irq_st[IRQ_ENDOP] = nxt_st.irq_st[IRQ_ENDOP] | ev_end;
    nxt_st.irq_st[IRQ_WDONE] = nxt_st.irq_st[IRQ_WDONE] | ev_wd;
    nxt_st.irq = |(nxt_st.irq_st & nxt_st.irq_en);
    // history of own aux drive stops the echo loop through the synchroniser
    nxt_st.drv_hist = {st_ff.drv_hist[1:0], st_ff.sda_lo};
    nxt_st.pri_lo = st_ff.mcfg[MC_PASS] && (st_ff.fsm == S_IDLE) && !sda_s &&
                    !(|st_ff.drv_hist) && !st_ff.sda_lo && !nxt_st.sda_lo;
  end
  // ==========================================================
  // registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.waitreq <= 1'b1;
      st_ff.bank <= RST_REG;
      st_ff.mcfg <= RST_REG;
      st_ff.irq_en <= RST_IRQ;
      st_ff.fsm <= S_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // ==========================================================
  // outputs; open-drain lines only ever pull low
  assign avs_readdata = st_ff.rdata;
  assign avs_waitrequest = st_ff.waitreq;
  assign irq = st_ff.irq;
  assign aux_data_line_out = 1'b0;
  assign aux_data_line_oe = st_ff.sda_lo;
  assign aux_clock_line_out = 1'b0;
  assign aux_clock_line_oe = st_ff.scl_lo;
  assign aux_pullup_en = st_ff.mcfg[MC_PU];
  assign pri_data_out = 1'b0;
  assign pri_data_oe = st_ff.pri_lo;
  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic byte_end;
  assign byte_end = (st_ff.fsm == S_BYTE) && tk.tick && st_ff.phase == 2'h3 && st_ff.bitn == 4'h8;
  AST_BANK_GATE: assert property (
    (wr && avs_address == IDX_TGT && !in_hub) |=> $stable(st_ff.tgt))
    else $error("target address written outside hub bank");
  AST_DIR_BIT: assert property (
    ($past(st_ff.fsm) == S_START && st_ff.fsm == S_BYTE) |-> st_ff.sh == {st_ff.tgt[7:1], 1'b0})
    else $error("first address byte not a write");
  AST_SUB_SENT: assert property (
    (byte_end && st_ff.step == 3'h0 && !st_ff.nack) |=> st_ff.sh == st_ff.sub && st_ff.step == 3'h1)
    else $error("sub-address not loaded");
  AST_COUNT: assert property (
    (byte_end && st_ff.step == 3'h3 && !st_ff.nack) |=> st_ff.left == numop && st_ff.left <= MAX_READ)
    else $error("read count wrong");
  AST_CFG_4C: assert property (
    (wr && in_hub && avs_address == IDX_MCFG && wd == 8'h4c) |=> st_ff.mcfg == 8'h4c ##0 aux_pullup_en)
    else $error("master config 4Ch not applied");
  AST_FIRST_BYTE: assert property (
    (byte_end && st_ff.step == 3'h4 && st_ff.ptr == 5'h0) |=> st_ff.hub[0] == $past(st_ff.sh))
    else $error("first byte not in first hub register");
  AST_WDATA: assert property (
    (byte_end && st_ff.step == 3'h1 && !st_ff.tgt[0] && !st_ff.nack) |=> st_ff.sh == st_ff.wval)
    else $error("write value not sent");
  AST_DONE_FLAGS: assert property (
    (st_ff.fsm == S_STOP && tk.tick && st_ff.phase == 2'h3 && st_ff.step == 3'h2) |=> st_ff.wdone && st_ff.endop)
    else $error("write done not flagged");
  AST_READ_CLEAR: assert property (
    (rd_flags && !ev_end && !ev_wd) |=> !st_ff.endop && !st_ff.wdone)
    else $error("flags not cleared on read");
  AST_PTR_LIMIT: assert property (
    st_ff.ptr <= 5'(MAX_READ))
    else $error("hub pointer past six");
  AST_PASS_SCL: assert property (
    (st_ff.mcfg[MC_PASS] && st_ff.fsm == S_IDLE && !pscl_s) |=> st_ff.scl_lo)
    else $error("pass-through clock not forwarded");
  AST_TRIGGER: assert property (
    (st_ff.fsm == S_IDLE && trig && st_ff.mcfg[MC_ON] && st_ff.tgt[0] && !st_ff.mcfg[MC_EXT] &&
     !st_ff.mcfg[MC_PASS]) |=> st_ff.fsm == S_START)
    else $error("read not started on trigger");
  COV_READ: cover property (byte_end && st_ff.step == 3'h4 && st_ff.left == 3'h1);
  COV_WRITE: cover property (ev_wd);
  COV_PASS: cover property (st_ff.pri_lo);
endmodule
`default_nettype wire

/* File: inc/aux_hub_pkg.sv */
/*
  constants, register indices and types of the auxiliary sensor hub master.
  assumes a 250 MHz system clock and a word-indexed register bus.
*/
`default_nettype none
package aux_hub_pkg;
  // ==========================================================
  // banks and register indices (byte address = 4 * index)
  localparam logic [7:0] BANK_MAIN = 8'h00;
  localparam logic [7:0] BANK_HUB = 8'h40;
  localparam logic [7:0] IDX_BANK = 8'h01;
  localparam logic [7:0] IDX_HUB1 = 8'h02;
  localparam logic [7:0] IDX_MCFG = 8'h14;
  localparam logic [7:0] IDX_TGT = 8'h15;
  localparam logic [7:0] IDX_SUB = 8'h16;
  localparam logic [7:0] IDX_CFG = 8'h17;
  localparam logic [7:0] IDX_WVAL = 8'h21;
  localparam logic [7:0] IDX_FLAGS = 8'h22;
  localparam logic [7:0] IDX_IRQ_ST = 8'h50;
  localparam logic [7:0] IDX_IRQ_CLR = 8'h51;
  localparam logic [7:0] IDX_IRQ_EN = 8'h52;
  // ==========================================================
  // fields
  localparam int MC_ON = 2;
  localparam int MC_PU = 3;
  localparam int MC_PASS = 4;
  localparam int MC_EXT = 5;
  localparam int MC_ONCE = 6;
  localparam int FL_ENDOP = 0;
  localparam int FL_WDONE = 7;
  localparam int IRQ_ENDOP = 0;
  localparam int IRQ_WDONE = 1;
  localparam int HUB_REGS = 18;
  localparam logic [2:0] MAX_READ = 3'h6;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [1:0] RST_IRQ = 2'h0;
  // ==========================================================
  // timing: quarter of an aux bit at 100 kHz
  localparam int CLK_MHZ = 250;
  localparam int QUARTER_NS = 2500;
  localparam int QUARTER_CYC = (QUARTER_NS * CLK_MHZ + 999) / 1000;
  // ==========================================================
  // engine states, gray along idle-start-byte-stop
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_START = 3'h1,
    S_BYTE = 3'h3,
    S_STOP = 3'h7,
    S_RESTART = 3'h2
  } fsm_t;
endpackage
`default_nettype wire

/* File: inc/tick_if.sv */
/*
  quarter-bit tick carrier between the hub master and its bit timer.
  assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface tick_if;
  logic run;
  logic tick;
  modport src (input run, output tick);
  modport snk (output run, input tick);
endinterface
`default_nettype wire

/* File: verilog/sync_2ff.sv */
/*
  two flip-flop synchroniser for a group of independent levels.
  assumes each bit is a slow level from outside the clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sync_t;
  sync_t st_ff;
  sync_t nxt_st;
  always_comb begin
    nxt_st.meta = d;
    nxt_st.q = st_ff.meta;
  end
  // idle bus lines are high, so reset to ones
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_ff <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign q = st_ff.q;
endmodule
`default_nettype wire

/* File: verilog/bit_timer.sv */
/*
  quarter-bit tick generator for the aux clock line.
  assumes run is held while a transfer is in progress.
*/
`timescale 1ns/100ps
`default_nettype none
module bit_timer
  import aux_hub_pkg::*;
#(
  parameter int DIV = QUARTER_CYC
) (
  input wire logic clk,
  input wire logic reset,
  tick_if.src tk
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } tmr_t;
  tmr_t st_ff;
  tmr_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (!tk.run) begin
      nxt_st.cnt = 16'h0;
    end else if (st_ff.cnt == 16'(DIV - 1)) begin
      nxt_st.cnt = 16'h0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 16'h1;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign tk.tick = st_ff.tick;
endmodule
`default_nettype wire

/* File: bench/ext_sensor.sv */
/*
  external i2c sensor: 256 byte registers, auto-increment pointer.
  assumes the bench resolves both open-drain wires with pull-ups.
*/
`timescale 1ns/100ps
`default_nettype none
module ext_sensor #(
  parameter logic [6:0] DEV = 7'h1e
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe
);
  // ==========================================================
  // bit and byte tracking off the wire edges
  logic [7:0] mem [256];
  logic [7:0] sh, tx, ptr;
  logic [3:0] cnt;
  logic act, first, sel, sub, go;
  initial begin
    sda_oe = 1'b0;
    act = 1'b0;
    go = 1'b0;
    ptr = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  always @(negedge sda) begin
    if (scl) begin
      act = 1'b1;
      first = 1'b1;
      go = 1'b0;
      cnt = 4'h8;
    end
  end
  always @(posedge sda) begin
    if (scl) act = 1'b0;
  end
  always @(posedge scl) begin
    if (act && cnt < 4'h8) sh = {sh[6:0], sda};
    else if (act && go && sda) go = 1'b0;
  end
  // data only changes while scl is low, so no false start or stop
  always @(negedge scl) begin
    if (act) begin
      cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      sda_oe = 1'b0;
      if (cnt == 4'h8 && go) ptr = ptr + 8'h01;
      else if (cnt == 4'h8) begin
        if (first) begin
          sel = (sh[7:1] == DEV);
          sub = !sh[0];
          go = sel && sh[0];
        end else if (sel && sub) begin
          ptr = sh;
          sub = 1'b0;
        end else if (sel) begin
          mem[ptr] = sh;
          ptr = ptr + 8'h01;
        end
        first = 1'b0;
        sda_oe = sel;
      end else if (go) begin
        if (cnt == 4'h0) tx = mem[ptr];
        sda_oe = !tx[3'h7 - cnt[2:0]];
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/sensor_hub_aux_i2c_master_bench.sv */
/*
  self-checking bench of the aux hub master with one external sensor.
  assumes the sensor model and pull-ups on both aux wires.
*/
`timescale 1ns/100ps
`default_nettype none
module sensor_hub_aux_i2c_master_bench
  import aux_hub_pkg::*;
;
  localparam logic [6:0] DEV = 7'h1e;
  // short quarter-bit keeps the run small; all transfers and waits fit well under the ceiling
  localparam int QDIV = 4;
  localparam int LIMIT = 40000;
  logic clk, reset, avs_read, avs_write, avs_waitrequest, irq, accel_sample_ready;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic aux_data_line_oe, aux_clock_line_oe, aux_pullup_en, pri_clock_in, pri_data_in, slv_oe;
  logic pri_data_oe;
  int miscompares, checks, cycles;
  wire scl = !aux_clock_line_oe;
  wire sda = !(aux_data_line_oe || slv_oe);
  aux_hub_master #(.QUARTER(QDIV)) u_dut (
    .clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .irq, .accel_sample_ready, .aux_data_line_in(sda),
    .aux_data_line_out(), .aux_data_line_oe, .aux_clock_line_out(), .aux_clock_line_oe,
    .aux_pullup_en, .pri_clock_in, .pri_data_in, .pri_data_out(), .pri_data_oe
  );
  ext_sensor #(.DEV(DEV)) u_sensor (.scl, .sda, .sda_oe(slv_oe));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========================================================
  // bus cycles and judging
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    d = avs_readdata[7:0];
    avs_read <= 1'b0;
  endtask
  task automatic trig();
    @(posedge clk);
    accel_sample_ready <= 1'b1;
    @(posedge clk);
    accel_sample_ready <= 1'b0;
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      conclude();
    end
  end
  task automatic setup(input logic [7:0] t, input logic [7:0] s, input logic [7:0] c, input logic [7:0] w);
    wr(IDX_BANK, BANK_HUB);
    wr(IDX_TGT, t);
    wr(IDX_SUB, s);
    wr(IDX_CFG, c);
    wr(IDX_WVAL, w);
  endtask
  // polling clears the flags, so the caller gets the only report
  task automatic wait_done(output logic [7:0] f);
    f = 8'h00;
    for (int i = 0; i < 200000 && f[FL_ENDOP] !== 1'b1; i++) rd(IDX_FLAGS, f);
  endtask
  task automatic stop_master();
    wr(IDX_BANK, BANK_HUB);
    wr(IDX_MCFG, 8'h08);
    repeat (2) @(posedge clk);
    // 08h keeps bit 3, so the pull-ups stay on
    check(aux_pullup_en, 1'b1);
    // 300 us is 120 quarter-bits; the wait scales with the bench's quarter
    repeat (120 * QDIV) @(posedge clk);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [7:0] v;
    wr(IDX_TGT, 8'h55);
    wr(IDX_BANK, BANK_HUB);
    rd(IDX_TGT, v);
    check(v, RST_REG);
    rd(IDX_MCFG, v);
    check(v, RST_REG);
    rd(8'h60, v);
    check(v, 8'h00);
    wr(IDX_BANK, BANK_MAIN);
    rd(IDX_IRQ_ST, v);
    check(v, {6'h0, RST_IRQ});
  endtask
  task automatic t_read_once();
    logic [7:0] f;
    u_sensor.mem[8'h4f] = 8'h3c;
    setup({DEV, 1'b1}, 8'h4f, 8'h01, 8'h00);
    wr(IDX_MCFG, 8'h4c);
    repeat (2) @(posedge clk);
    check(aux_pullup_en, 1'b1);
    wr(IDX_BANK, BANK_MAIN);
    wr(IDX_IRQ_EN, 8'h01);
    trig();
    wait_done(f);
    check(f, 8'h01 << FL_ENDOP);
    rd(IDX_FLAGS, f);
    check(f, 8'h00);
    check(irq, 1'b1);
    wr(IDX_IRQ_EN, 8'h00);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    wr(IDX_IRQ_EN, 8'h01);
    repeat (2) @(posedge clk);
    check(irq, 1'b1);
    wr(IDX_IRQ_CLR, 8'h01);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    stop_master();
    rd(IDX_HUB1, f);
    check(f, 8'h3c);
    wr(IDX_BANK, BANK_MAIN);
  endtask
  task automatic t_write_once();
    logic [7:0] f;
    logic busy;
    busy = 1'b0;
    setup({DEV, 1'b0}, 8'h60, 8'h00, 8'h8c);
    wr(IDX_MCFG, 8'h4c);
    wr(IDX_BANK, BANK_MAIN);
    trig();
    wait_done(f);
    check(f, (8'h01 << FL_WDONE) | (8'h01 << FL_ENDOP));
    check(u_sensor.mem[8'h60], 8'h8c);
    trig();
    repeat (3000) begin
      @(posedge clk);
      if (aux_data_line_oe === 1'b1 || aux_clock_line_oe === 1'b1) busy = 1'b1;
    end
    check(busy, 1'b0);
    stop_master();
  endtask
  task automatic t_cont();
    logic [7:0] v;
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 6; k++) u_sensor.mem[8'h68 + k] = 8'(8'ha0 + 8'h10 * r + k);
      if (r == 0) begin
        setup({DEV, 1'b1}, 8'h68, {5'h0, MAX_READ}, 8'h00);
        wr(IDX_MCFG, 8'h4c);
      end
      wr(IDX_BANK, BANK_MAIN);
      trig();
      wait_done(v);
      check(v, 8'h01 << FL_ENDOP);
      wr(IDX_BANK, BANK_HUB);
      for (int k = 0; k < 7; k++) begin
        rd(8'(IDX_HUB1 + k), v);
        check(v, (k < 6) ? 8'(8'ha0 + 8'h10 * r + k) : 8'h00);
      end
    end
    stop_master();
    wr(IDX_BANK, BANK_MAIN);
  endtask
  // primary clock toggles every four edges, a 32 ns period; three-cycle lag to the aux lines
  task automatic t_pass();
    wr(IDX_BANK, BANK_HUB);
    wr(IDX_MCFG, 8'h10);
    repeat (2) @(posedge clk);
    check(aux_pullup_en, 1'b0);
    for (int i = 0; i < 8; i++) begin
      pri_clock_in <= ~pri_clock_in;
      if (i[0]) pri_data_in <= ~pri_data_in;
      repeat (4) @(posedge clk);
      check(aux_clock_line_oe, !pri_clock_in);
      check(aux_data_line_oe, !pri_data_in);
    end
    // a low made by the sensor echoes to the primary data line
    u_sensor.sda_oe <= 1'b1;
    repeat (8) @(posedge clk);
    check(pri_data_oe, 1'b1);
    u_sensor.sda_oe <= 1'b0;
    repeat (8) @(posedge clk);
    check(pri_data_oe, 1'b0);
    wr(IDX_MCFG, 8'h00);
    wr(IDX_BANK, BANK_MAIN);
  endtask
  initial begin
    reset = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    accel_sample_ready = 1'b0;
    pri_clock_in = 1'b1;
    pri_data_in = 1'b1;
    miscompares = 0;
    checks = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_read_once();
    t_write_once();
    t_cont();
    t_pass();
    conclude();
  end
endmodule
`default_nettype wire
